/* File: msd_pkg.sv */
// constants and types shared by the motion stop/start detector
`default_nettype none
package msd_pkg;
  localparam int NUM_AXES = 3;                     // x, y, z
  localparam int AXIS_X   = 0;
  localparam int AXIS_Y   = 1;
  localparam int AXIS_Z   = 2;
  localparam int CODE_W   = 10;                    // converter result width
  localparam int VAL_W    = 11;                    // signed corrected value
  localparam int DIF_W    = 12;                    // difference of two values
  localparam int DEV_W    = 13;                    // direction-signed deviation
  localparam logic signed [VAL_W-1:0] ZERO_G_VAL = 11'h1F4; // code that reads 0 g
  localparam int ONE_G_COUNTS = 137;               // counts per g after correction

  // timing
  localparam int CLK_PERIOD_NS    = 8;
  localparam int SAMPLE_PERIOD_US = 4000;
  localparam int SAMPLE_PERIOD_MS = 4;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int STOP_TIME_MS     = 120;
  localparam int STOP_SAMPLES     = (STOP_TIME_MS + SAMPLE_PERIOD_MS - 1) / SAMPLE_PERIOD_MS;
  localparam int FALL_TIME_MS     = 20;
  localparam int FALL_SAMPLES     = (FALL_TIME_MS + SAMPLE_PERIOD_MS - 1) / SAMPLE_PERIOD_MS;

  // thresholds in counts
  localparam int QUIET_TH    = 20;
  localparam int START_TH    = 30;
  localparam int FALL_MARGIN = 5;

  // per-axis state
  typedef enum logic [1:0] {
    MSD_ST_WAIT = 2'b00,                           // no rest seen yet
    MSD_ST_REST = 2'b01,                           // stopped, baseline valid
    MSD_ST_MOVE = 2'b10,                           // moving, tracking peak
    MSD_ST_PEAK = 2'b11                            // first peak held
  } msd_state_e;

  // physical meaning of a direction
  typedef enum logic [2:0] {
    MSD_MO_NONE  = 3'b000,
    MSD_MO_NEAR  = 3'b001,                         // x plus
    MSD_MO_BACK  = 3'b010,                         // x minus
    MSD_MO_LEFT  = 3'b011,                         // y plus
    MSD_MO_RIGHT = 3'b100,                         // y minus
    MSD_MO_DOWN  = 3'b101,                         // z plus
    MSD_MO_UP    = 3'b110                          // z minus
  } msd_motion_e;

  // raw converter codes of all axes
  typedef struct packed {
    logic [NUM_AXES-1:0][CODE_W-1:0] code;
  } msd_samples_s;

  // per-axis result
  typedef struct packed {
    logic                    stopped;              // level: at rest
    logic                    move_start;           // pulse: movement began
    logic                    dir_neg;              // level: direction minus
    msd_motion_e             motion;               // level: decoded direction
    logic                    peak_done;            // pulse: first peak final
    logic signed [DEV_W-1:0] peak;                 // peak deviation, direction-signed
    logic signed [VAL_W-1:0] baseline;             // rest average
  } msd_axis_out_s;
endpackage : msd_pkg
`default_nettype wire

/* File: msd_tick.sv */
// sample cadence strobe generator
`default_nettype none
module msd_tick #(
  parameter int PERIOD = msd_pkg::SAMPLE_CYCLES    // cycles between strobes
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output var  logic tick                           // one-cycle pulse
);
  import msd_pkg::*;

  localparam int CNT_W = $clog2(PERIOD);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

  logic [CNT_W-1:0] cnt_q, cnt_d;                  // cycle count in period
  logic             tick_d;

  // wrap the counter and flag the last cycle
  always_comb begin
    tick_d = (cnt_q == LAST);
    cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
  end

  // register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule // msd_tick
`default_nettype wire

/* File: msd_top.sv */
// three-axis rest, movement start, direction and first-peak detector
`default_nettype none
module msd_top #(
  parameter int SAMPLE_CYCLES = msd_pkg::SAMPLE_CYCLES, // cycles per sample
  parameter int QUIET_TH      = msd_pkg::QUIET_TH,      // largest quiet step
  parameter int START_TH      = msd_pkg::START_TH,      // least start deviation
  parameter int STOP_SAMPLES  = msd_pkg::STOP_SAMPLES,  // quiet run for rest
  parameter int FALL_SAMPLES  = msd_pkg::FALL_SAMPLES,  // samples below peak
  parameter int FALL_MARGIN   = msd_pkg::FALL_MARGIN    // least drop from peak
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire msd_pkg::msd_samples_s axis_analog_inputs,
  output var  logic                  sample_strobe,
  output var  msd_pkg::msd_axis_out_s axis_status [msd_pkg::NUM_AXES]
);
  import msd_pkg::*;

  localparam int RUN_W  = $clog2(STOP_SAMPLES + 1);
  localparam int FALL_W = $clog2(FALL_SAMPLES + 1);
  localparam int SUM_W  = VAL_W + RUN_W + 1;
  localparam logic [DIF_W-1:0]        QUIET_LIM = DIF_W'(QUIET_TH);
  localparam logic [DIF_W-1:0]        START_LIM = DIF_W'(START_TH);
  localparam logic signed [DEV_W-1:0] DROP_LIM  = DEV_W'(FALL_MARGIN);
  localparam logic [RUN_W-1:0]        RUN_LAST  = RUN_W'(STOP_SAMPLES - 1);
  localparam logic [FALL_W-1:0]       FALL_LAST = FALL_W'(FALL_SAMPLES - 1);
  localparam logic signed [SUM_W-1:0] STOP_DIV  = SUM_W'(STOP_SAMPLES);

  // magnitude of a signed difference
  function automatic logic [DIF_W-1:0] mag(input logic signed [DIF_W-1:0] v);
    mag = v[DIF_W-1] ? DIF_W'(-v) : v;
  endfunction

  // direction sign to physical motion, per axis
  function automatic msd_motion_e motion_of(input int axis, input logic neg);
    motion_of = MSD_MO_NONE;
    if (axis == AXIS_X) begin
      motion_of = neg ? MSD_MO_BACK : MSD_MO_NEAR;
    end else if (axis == AXIS_Y) begin
      motion_of = neg ? MSD_MO_RIGHT : MSD_MO_LEFT;
    end else begin
      motion_of = neg ? MSD_MO_UP : MSD_MO_DOWN;
    end
  endfunction

  logic tick;                                      // sample cadence pulse

  // fixed sample cadence
  msd_tick #(
    .PERIOD (SAMPLE_CYCLES)
  ) u_tick (
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick)
  );

  // sample capture: codes are latched on the strobe, judged one cycle later
  msd_samples_s samp_q, samp_d;
  logic         samp_vld_q, samp_vld_d;

  always_comb begin
    samp_d     = tick ? axis_analog_inputs : samp_q;
    samp_vld_d = tick;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_q     <= '0;
      samp_vld_q <= 1'b0;
    end else begin
      samp_q     <= samp_d;
      samp_vld_q <= samp_vld_d;
    end
  end

  // per-axis state
  logic signed [VAL_W-1:0]  prev_q    [NUM_AXES]; // last sample value
  logic signed [VAL_W-1:0]  prev_d    [NUM_AXES];
  logic                     primed_q  [NUM_AXES]; // a previous sample exists
  logic                     primed_d  [NUM_AXES];
  logic [RUN_W-1:0]         run_q     [NUM_AXES]; // quiet samples so far
  logic [RUN_W-1:0]         run_d     [NUM_AXES];
  logic signed [SUM_W-1:0]  sum_q     [NUM_AXES]; // quiet-run sum
  logic signed [SUM_W-1:0]  sum_d     [NUM_AXES];
  logic signed [VAL_W-1:0]  base_q    [NUM_AXES]; // rest average
  logic signed [VAL_W-1:0]  base_d    [NUM_AXES];
  msd_state_e               state_q   [NUM_AXES];
  msd_state_e               state_d   [NUM_AXES];
  logic                     dir_q     [NUM_AXES]; // 1 = minus
  logic                     dir_d     [NUM_AXES];
  logic signed [DEV_W-1:0]  peak_q    [NUM_AXES]; // largest deviation so far
  logic signed [DEV_W-1:0]  peak_d    [NUM_AXES];
  logic [FALL_W-1:0]        fall_q    [NUM_AXES]; // samples below the peak
  logic [FALL_W-1:0]        fall_d    [NUM_AXES];
  msd_axis_out_s            out_q     [NUM_AXES];
  msd_axis_out_s            out_d     [NUM_AXES];

  // combinational views; all but val_c and start_c are also watched by the checks
  logic signed [VAL_W-1:0]  val_c     [NUM_AXES]; // offset-corrected sample
  logic signed [DIF_W-1:0]  dev_c     [NUM_AXES]; // sample minus baseline
  logic [DIF_W-1:0]         adev_c    [NUM_AXES]; // magnitude of deviation
  logic signed [DEV_W-1:0]  sdev_c    [NUM_AXES]; // deviation along direction
  logic signed [DEV_W-1:0]  drop_c    [NUM_AXES]; // peak minus deviation
  logic                     quiet_c   [NUM_AXES];
  logic                     start_c   [NUM_AXES];
  logic                     stop_c    [NUM_AXES];

  // next-state for all axes; each axis stands alone
  always_comb begin
    for (int a = 0; a < NUM_AXES; a++) begin
      logic signed [DIF_W-1:0] step;
      logic signed [SUM_W-1:0] acc;
      step = '0;
      acc  = '0;
      // zero g reads as zero
      val_c[a]  = $signed({1'b0, samp_q.code[a]}) - ZERO_G_VAL;
      step      = {val_c[a][VAL_W-1], val_c[a]} - {prev_q[a][VAL_W-1], prev_q[a]};
      dev_c[a]  = {val_c[a][VAL_W-1], val_c[a]} - {base_q[a][VAL_W-1], base_q[a]};
      adev_c[a] = mag(dev_c[a]);
      sdev_c[a] = dir_q[a] ? -{dev_c[a][DIF_W-1], dev_c[a]} : {dev_c[a][DIF_W-1], dev_c[a]};
      drop_c[a] = peak_q[a] - sdev_c[a];
      quiet_c[a] = primed_q[a] && (mag(step) <= QUIET_LIM);
      acc        = sum_q[a] + SUM_W'(val_c[a]);
      stop_c[a]  = samp_vld_q && quiet_c[a] && (run_q[a] == RUN_LAST);
      start_c[a] = samp_vld_q && (state_q[a] == MSD_ST_REST) && (adev_c[a] >= START_LIM);

      // hold by default
      prev_d[a]   = prev_q[a];
      primed_d[a] = primed_q[a];
      run_d[a]    = run_q[a];
      sum_d[a]    = sum_q[a];
      base_d[a]   = base_q[a];
      state_d[a]  = state_q[a];
      dir_d[a]    = dir_q[a];
      peak_d[a]   = peak_q[a];
      fall_d[a]   = fall_q[a];

      if (samp_vld_q) begin
        prev_d[a]   = val_c[a];
        primed_d[a] = 1'b1;
        // quiet run bookkeeping; any loud step restarts the run
        if (!quiet_c[a]) begin
          run_d[a] = '0;
          sum_d[a] = '0;
        end else if (stop_c[a]) begin
          run_d[a] = '0;
          sum_d[a] = '0;
          // a start seen on this same sample keeps the old baseline it was measured against
          if (!start_c[a]) begin
            base_d[a]  = VAL_W'(acc / STOP_DIV);
            state_d[a] = MSD_ST_REST;
          end
        end else begin
          run_d[a] = run_q[a] + 1'b1;
          sum_d[a] = acc;
        end

        unique case (state_q[a])
          MSD_ST_WAIT: begin
            // nothing until the first rest
          end
          MSD_ST_REST: begin
            if (start_c[a]) begin
              state_d[a] = MSD_ST_MOVE;
              dir_d[a]   = dev_c[a][DIF_W-1];
              peak_d[a]  = DEV_W'(adev_c[a]);
              fall_d[a]  = '0;
            end
          end
          MSD_ST_MOVE: begin
            if (stop_c[a]) begin
              // movement ended before a peak was confirmed
            end else if (sdev_c[a] > peak_q[a]) begin
              peak_d[a] = sdev_c[a];
              fall_d[a] = '0;
            end else if (sdev_c[a] < peak_q[a]) begin
              if (fall_q[a] != FALL_LAST) begin
                fall_d[a] = fall_q[a] + 1'b1;
              end else if (drop_c[a] >= DROP_LIM) begin
                state_d[a] = MSD_ST_PEAK;
              end else begin
                // slight dip only: restart the wait, peak stays
                fall_d[a] = '0;
              end
            end else begin
              // equal to the peak: neither rising nor falling
            end
          end
          MSD_ST_PEAK: begin
            // peak held until the next rest
          end
        endcase
      end

      // registered view of the axis
      out_d[a].stopped    = (state_d[a] == MSD_ST_REST);
      out_d[a].move_start = start_c[a];
      out_d[a].dir_neg    = dir_d[a];
      out_d[a].motion     = (state_d[a] == MSD_ST_WAIT) ? MSD_MO_NONE : motion_of(a, dir_d[a]);
      out_d[a].peak_done  = samp_vld_q && (state_q[a] == MSD_ST_MOVE) && (state_d[a] == MSD_ST_PEAK);
      out_d[a].peak       = peak_d[a];
      out_d[a].baseline   = base_d[a];
    end
  end

  // register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        prev_q[a]   <= '0;
        primed_q[a] <= 1'b0;
        run_q[a]    <= '0;
        sum_q[a]    <= '0;
        base_q[a]   <= '0;
        state_q[a]  <= MSD_ST_WAIT;
        dir_q[a]    <= 1'b0;
        peak_q[a]   <= '0;
        fall_q[a]   <= '0;
        out_q[a]    <= '0;
      end
      sample_strobe <= 1'b0;
    end else begin
      for (int a = 0; a < NUM_AXES; a++) begin
        prev_q[a]   <= prev_d[a];
        primed_q[a] <= primed_d[a];
        run_q[a]    <= run_d[a];
        sum_q[a]    <= sum_d[a];
        base_q[a]   <= base_d[a];
        state_q[a]  <= state_d[a];
        dir_q[a]    <= dir_d[a];
        peak_q[a]   <= peak_d[a];
        fall_q[a]   <= fall_d[a];
        out_q[a]    <= out_d[a];
      end
      sample_strobe <= samp_vld_q;
    end
  end

  assign axis_status = out_q;

  // helper for the cadence check: cycles since the last strobe, saturating
  localparam int GAP_W = $clog2(SAMPLE_CYCLES + 1);
  logic [GAP_W-1:0] gap_q;                         // cycles since the last strobe
  logic [GAP_W-1:0] gap_d;
  logic             seen_q;                        // a strobe was seen since reset
  logic             seen_d;

  // next values: restart on a strobe, stop at one full period so a lost strobe cannot wrap
  always_comb begin
    gap_d = gap_q;
    if (tick) begin
      gap_d = '0;
    end else if (gap_q != GAP_W'(SAMPLE_CYCLES)) begin
      gap_d = gap_q + 1'b1;
    end
    seen_d = seen_q | tick;
  end

  // register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
    end
  end

  sample_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && seen_q) |-> (gap_q == GAP_W'(SAMPLE_CYCLES - 1)))
    else $error("sample strobe spacing wrong");

  sample_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
    tick |=> (samp_vld_q && (samp_q == $past(axis_analog_inputs))))
    else $error("sample not captured on strobe");

  for (genvar g = 0; g < NUM_AXES; g++) begin : g_chk
    stop_decl_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(out_q[g].stopped) |-> ($past(quiet_c[g]) && ($past(run_q[g]) == RUN_LAST)))
      else $error("rest declared without full quiet run");

    start_rest_a: assert property (@(posedge clk) disable iff (!rst_n)
      out_q[g].move_start |-> ($past(state_q[g]) == MSD_ST_REST) && (state_q[g] == MSD_ST_MOVE))
      else $error("movement start not from rest");

    start_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      out_q[g].move_start |-> ($past(adev_c[g]) >= START_LIM))
      else $error("movement start below threshold");

    start_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
      out_q[g].move_start |-> (out_q[g].dir_neg == $past(dev_c[g][DIF_W-1])))
      else $error("direction does not follow deviation sign");

    motion_map_a: assert property (@(posedge clk) disable iff (!rst_n)
      (out_q[g].move_start && !out_q[g].dir_neg) |->
        (out_q[g].motion == ((g == AXIS_X) ? MSD_MO_NEAR : (g == AXIS_Y) ? MSD_MO_LEFT : MSD_MO_DOWN)))
      else $error("motion decode wrong");

    peak_track_a: assert property (@(posedge clk) disable iff (!rst_n)
      (samp_vld_q && (state_q[g] == MSD_ST_MOVE) && !stop_c[g] && (sdev_c[g] > peak_q[g]))
        |=> (peak_q[g] == $past(sdev_c[g])) && (fall_q[g] == '0))
      else $error("peak not tracked");

    peak_final_a: assert property (@(posedge clk) disable iff (!rst_n)
      out_q[g].peak_done |-> (($past(fall_q[g]) == FALL_LAST) && ($past(drop_c[g]) >= DROP_LIM)))
      else $error("peak confirmed too early or too small");
  end
endmodule // msd_top
`default_nettype wire

/* File: msd_adc_model.sv */
// behavioural converter model feeding the three axis codes to the detector
`default_nettype none
module msd_adc_model (
  input  wire logic                  clk,       // sample clock
  input  wire logic                  rst_n,     // asynchronous reset, active low
  input  wire msd_pkg::msd_samples_s level_in,  // sensor level per axis, as a code
  output var  msd_pkg::msd_samples_s codes      // latest conversion results
);
  import msd_pkg::*;

  msd_samples_s codes_d;                        // next conversion results

  // converts continuously, so a level set just after a strobe is settled
  // long before the detector takes its next sample
  always_comb begin
    codes_d = level_in;                         // 10-bit field bounds the code
  end

  // result register; cleared in reset, the detector ignores it until its first strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      codes <= '0;
    end else begin
      codes <= codes_d;
    end
  end
endmodule // msd_adc_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the motion stop/start detector
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import msd_pkg::*;

  localparam int SC = 16;                       // shortened sample period in cycles

  // one table row: deviation per axis and which axes should report a start
  typedef struct {
    int                  dev [NUM_AXES];
    logic [NUM_AXES-1:0] mv;
  } msd_row_s;

  logic          clk         = 1'h0;            // 125 MHz clock
  logic          rst_n       = 1'h0;            // held low at start
  msd_samples_s  level       = '0;              // levels handed to the converter
  msd_samples_s  codes;                         // converter results into the detector
  logic          strobe;                        // result-ready pulse
  msd_axis_out_s status [NUM_AXES];             // per-axis results
  int            fail_count  = 0;
  int            num_checks  = 0;
  int            cyc         = 0;               // free-running cycle count
  int            last_strobe = 0;               // cycle of the previous strobe
  bit            have_last   = 1'h0;            // spacing only known after one strobe
  int            sum         = 0;               // running sum for the expected average
  int            base [NUM_AXES] = '{480, 530, 500};
  msd_motion_e   mot [NUM_AXES][2] = '{'{MSD_MO_NEAR, MSD_MO_BACK}, '{MSD_MO_LEFT, MSD_MO_RIGHT},
                                       '{MSD_MO_DOWN, MSD_MO_UP}};
  // threshold boundaries: 30 starts, 29 does not; z at 30 in both signs, y at minus only; x minus is tried at 31 only
  msd_row_s      rows [3] = '{'{'{30, 40, 29}, 3'h3}, '{'{-31, -30, 30}, 3'h7}, '{'{29, -29, -30}, 3'h4}};

  // clock and cycle counter
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  msd_adc_model adc_u (.clk(clk), .rst_n(rst_n), .level_in(level), .codes(codes));

  msd_top #(.SAMPLE_CYCLES(SC)) dut_u (
    .clk                (clk),
    .rst_n              (rst_n),
    .axis_analog_inputs (codes),
    .sample_strobe      (strobe),
    .axis_status        (status)
  );

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // present one sample right after a strobe and wait until its result shows
  task automatic apply(input int x, input int y, input int z);
    int n;
    @(posedge clk);
    level.code[AXIS_X] <= 10'(x);
    level.code[AXIS_Y] <= 10'(y);
    level.code[AXIS_Z] <= 10'(z);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (strobe !== 1'h1 && n < 40);
    if (n >= 40) begin
      chk(strobe, 1'h1, "no sample strobe");
    end else if (have_last) begin
      chk(cyc - last_strobe, SC, "strobe spacing");
    end
    last_strobe = cyc;
    have_last = 1'h1;
  endtask

  // hold every axis at its base level until rest is declared
  task automatic rest_all();
    repeat (STOP_SAMPLES + 1) apply(base[0], base[1], base[2]);
    for (int a = 0; a < NUM_AXES; a++) begin
      chk(status[a].stopped, 1'h1, "stopped");
      chk(status[a].baseline, base[a] - ZERO_G_VAL, "baseline");
    end
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    // table: rest, then one step away from the baseline
    foreach (rows[r]) begin
      rest_all();
      apply(base[0] + rows[r].dev[0], base[1] + rows[r].dev[1], base[2] + rows[r].dev[2]);
      for (int a = 0; a < NUM_AXES; a++) begin
        chk(status[a].move_start, rows[r].mv[a], "start pulse");
        if (rows[r].mv[a]) begin
          chk(status[a].dir_neg, rows[r].dev[a] < 0, "direction");
          chk(status[a].motion, mot[a][rows[r].dev[a] < 0], "motion");
          chk(status[a].peak, rows[r].dev[a] < 0 ? -rows[r].dev[a] : rows[r].dev[a], "start peak");
        end
      end
    end
    // reset in mid-run clears everything at once
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    #1;
    chk(strobe, 1'h0, "strobe in reset");
    for (int a = 0; a < NUM_AXES; a++) begin
      chk(status[a], '0, "status in reset");
    end
    @(posedge clk);
    rst_n <= 1'h1;
    have_last = 1'h0;
    // x steps by exactly 20 (quiet), z by 21 (loud), y constant
    for (int i = 1; i <= STOP_SAMPLES + 1; i++) begin
      apply(i % 2 ? 500 : 520, 400, i % 2 ? 600 : 579);
      if (i > 1) begin
        sum += (i % 2 ? 500 : 520) - ZERO_G_VAL;
      end
      if (i == STOP_SAMPLES) begin
        chk(status[AXIS_X].stopped, 1'h0, "early rest x");
        chk(status[AXIS_Y].stopped, 1'h0, "early rest y");
      end
    end
    chk(status[AXIS_X].stopped, 1'h1, "quiet at boundary");
    chk(status[AXIS_X].baseline, sum / STOP_SAMPLES, "quiet average");
    chk(status[AXIS_Y].baseline, 400 - ZERO_G_VAL, "constant average");
    chk(status[AXIS_Z].stopped, 1'h0, "loud axis apart");
    // z never rested: a large deviation must not start it
    apply(500, 400, 800);
    chk(status[AXIS_Z].move_start, 1'h0, "start without rest");
    chk(status[AXIS_Z].motion, MSD_MO_NONE, "no direction yet");
    // x peak tracking around a baseline of 10
    apply(550, 400, 800);
    chk(status[AXIS_X].move_start, 1'h1, "x start");
    chk(status[AXIS_X].peak, 40, "first peak");
    apply(570, 400, 800);
    chk(status[AXIS_X].move_start, 1'h0, "start is one pulse");
    chk(status[AXIS_X].peak, 60, "rising peak");
    apply(570, 400, 800);
    foreach (rows[r]) apply(569 - r, 400, 800);
    apply(566, 400, 800);
    apply(566, 400, 800);
    chk(status[AXIS_X].peak_done, 1'h0, "drop of 4 too small");
    for (int i = 1; i <= FALL_SAMPLES; i++) begin
      apply(565, 400, 800);
      chk(status[AXIS_X].peak_done, i == FALL_SAMPLES, "peak confirmation");
    end
    chk(status[AXIS_X].peak, 60, "peak held");
    summarize();
  end

  // watchdog: about 140 samples expected, allow 400
  initial begin
    #(SC * CLK_PERIOD_NS * 400);
    fail_count++;
    summarize();
  end
endmodule // testbench
`default_nettype wire
